// file: hw/vmi_defs.vh
/*
 * Constants of the video memory interpolator: widths, memory layout,
 * interpolation scaling, fetch sequencing and state codes.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef VMI_DEFS_VH
`define VMI_DEFS_VH

`define VMI_DATA_W      8
`define VMI_COORD_W     4
`define VMI_FRAC_W      4
`define VMI_FIELD_W     2
`define VMI_ADDR_W      10
`define VMI_MEM_DEPTH   1024
`define VMI_FIELD_LAST  2'h2
`define VMI_RD_FIELD_RST 2'h2
`define VMI_TAPS        5'h10
`define VMI_WPROD_W     14
`define VMI_ACC_W       24
`define VMI_OUT_LSB     12
`define VMI_COORD_MAX   4'hf

`define VMI_ST_IDLE     2'h0
`define VMI_ST_FETCH    2'h1
`define VMI_ST_DONE     2'h2

`endif

// file: hw/vmi_interpolator.v
/*
 * Field store and 4x4 interpolator for luma, chroma, key and drop shadow.
 * Assumes the filter stage writes column-ordered samples with coordinates,
 * and the post-transform stage presents main and shadow addresses with blanking.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vmi_defs.vh"

module vmi_interpolator (
	input  wire                      CLOCK,
	input  wire                      RST_N,
	input  wire                      IN_VALID,
	input  wire [`VMI_COORD_W-1:0]   IN_COL,
	input  wire [`VMI_COORD_W-1:0]   IN_ROW,
	input  wire [`VMI_DATA_W-1:0]    IN_LUMA,
	input  wire [`VMI_DATA_W-1:0]    IN_CHROMA,
	input  wire [`VMI_DATA_W-1:0]    IN_KEY,
	input  wire                      IN_FIELD_END,
	input  wire                      ADDR_VALID,
	output wire                      ADDR_READY,
	input  wire [`VMI_COORD_W-1:0]   ADDR_X,
	input  wire [`VMI_FRAC_W-1:0]    ADDR_XF,
	input  wire [`VMI_COORD_W-1:0]   ADDR_Y,
	input  wire [`VMI_FRAC_W-1:0]    ADDR_YF,
	input  wire [`VMI_COORD_W-1:0]   SHADOW_X,
	input  wire [`VMI_FRAC_W-1:0]    SHADOW_XF,
	input  wire [`VMI_COORD_W-1:0]   SHADOW_Y,
	input  wire [`VMI_FRAC_W-1:0]    SHADOW_YF,
	input  wire                      BLANK,
	input  wire                      UNIFIED_MODE,
	input  wire                      DUAL_KEY_UNIT,
	input  wire                      SHADOW_ENABLE,
	output reg                       OUT_VALID,
	output reg  [`VMI_DATA_W-1:0]    OUT_LUMA,
	output reg  [`VMI_DATA_W-1:0]    OUT_CHROMA,
	output reg  [`VMI_DATA_W-1:0]    OUT_KEY,
	output reg  [`VMI_DATA_W-1:0]    OUT_SHADOW
);

	reg  [`VMI_DATA_W-1:0]  mem_luma   [0:`VMI_MEM_DEPTH-1];
	reg  [`VMI_DATA_W-1:0]  mem_chroma [0:`VMI_MEM_DEPTH-1];
	reg  [`VMI_DATA_W-1:0]  mem_key    [0:`VMI_MEM_DEPTH-1];

	reg  [1:0]               state_reg;
	reg  [4:0]               cnt_reg;
	reg  [`VMI_FIELD_W-1:0]  wr_field_reg;
	reg  [`VMI_FIELD_W-1:0]  rd_field_reg;
	reg  [`VMI_COORD_W-1:0]  x_reg;
	reg  [`VMI_FRAC_W-1:0]   xf_reg;
	reg  [`VMI_COORD_W-1:0]  y_reg;
	reg  [`VMI_FRAC_W-1:0]   yf_reg;
	reg  [`VMI_COORD_W-1:0]  sx_reg;
	reg  [`VMI_FRAC_W-1:0]   sxf_reg;
	reg  [`VMI_COORD_W-1:0]  sy_reg;
	reg  [`VMI_FRAC_W-1:0]   syf_reg;
	reg                      blank_reg;
	reg                      phase_reg;
	reg  [`VMI_WPROD_W-1:0]  w_reg;
	reg  [`VMI_WPROD_W-1:0]  sw_reg;
	reg  [`VMI_DATA_W-1:0]   rd_luma_reg;
	reg  [`VMI_DATA_W-1:0]   rd_chroma_reg;
	reg  [`VMI_DATA_W-1:0]   rd_key_reg;
	reg  [`VMI_DATA_W-1:0]   rd_shadow_reg;
	reg  [`VMI_ACC_W-1:0]    acc_luma_reg;
	reg  [`VMI_ACC_W-1:0]    acc_chroma_reg;
	reg  [`VMI_ACC_W-1:0]    acc_key_reg;
	reg  [`VMI_ACC_W-1:0]    acc_shadow_reg;

	wire [1:0]               tap_x;
	wire [1:0]               tap_y;
	wire [`VMI_ADDR_W-1:0]   wr_addr;
	wire [`VMI_ADDR_W-1:0]   rd_addr;
	wire [`VMI_ADDR_W-1:0]   sh_addr;
	wire                     full_shadow;
	wire                     half_mode;
	wire                     key_upd;
	wire                     shadow_upd;

	// Tap position around the base, clamped to the stored raster
	function [`VMI_COORD_W-1:0] tap_pos;
		input [`VMI_COORD_W-1:0] base;
		input [1:0]              t;
		reg   [4:0]              v;
		begin
			v = {1'b0, base} + {3'h0, t};
			if (v == 5'h00)
				tap_pos = 4'h0;
			else if (v > `VMI_TAPS)
				tap_pos = `VMI_COORD_MAX;
			else
				tap_pos = v[3:0] - 4'h1;
		end
	endfunction

	// Four-tap weights from the fraction, summing to 64
	function [6:0] weight;
		input [`VMI_FRAC_W-1:0] f;
		input [1:0]             t;
		begin
			case (t)
				2'h0: weight = 7'h10 - {3'h0, f};
				2'h1: weight = 7'h20 - {3'h0, f};
				2'h2: weight = 7'h10 + {3'h0, f};
				default: weight = {3'h0, f};
			endcase
		end
	endfunction

	function [`VMI_ACC_W-1:0] mac;
		input [`VMI_ACC_W-1:0]   acc;
		input [`VMI_DATA_W-1:0]  d;
		input [`VMI_WPROD_W-1:0] w;
		reg   [`VMI_ACC_W-1:0]   p;
		begin
			p = {{(`VMI_ACC_W-`VMI_DATA_W){1'b0}}, d} * {{(`VMI_ACC_W-`VMI_WPROD_W){1'b0}}, w};
			mac = acc + p;
		end
	endfunction

	assign tap_x = cnt_reg[1:0];
	assign tap_y = cnt_reg[3:2];
	assign wr_addr = {wr_field_reg, IN_ROW, IN_COL};
	assign rd_addr = {rd_field_reg, tap_pos(y_reg, tap_y), tap_pos(x_reg, tap_x)};
	assign sh_addr = {rd_field_reg, tap_pos(sy_reg, tap_y), tap_pos(sx_reg, tap_x)};
	assign full_shadow = UNIFIED_MODE | DUAL_KEY_UNIT;
	assign half_mode = ~full_shadow & SHADOW_ENABLE;
	assign key_upd = ~half_mode | ~phase_reg;
	assign shadow_upd = full_shadow | (half_mode & phase_reg);
	assign ADDR_READY = (state_reg == `VMI_ST_IDLE) & RST_N;

	// Sample store, written into the field being filled
	always @(posedge CLOCK) begin
		if (IN_VALID) begin
			mem_luma[wr_addr] <= IN_LUMA;
			mem_chroma[wr_addr] <= IN_CHROMA;
			mem_key[wr_addr] <= IN_KEY;
		end
		rd_luma_reg <= mem_luma[rd_addr];
		rd_chroma_reg <= mem_chroma[rd_addr];
		rd_key_reg <= mem_key[rd_addr];
		rd_shadow_reg <= mem_key[sh_addr];
	end

	// Three fields rotate; reads use the last completed one
	always @(posedge CLOCK) begin
		if (!RST_N) begin
			wr_field_reg <= 2'h0;
			rd_field_reg <= `VMI_RD_FIELD_RST;
		end else if (IN_FIELD_END) begin
			rd_field_reg <= wr_field_reg;
			if (wr_field_reg == `VMI_FIELD_LAST)
				wr_field_reg <= 2'h0;
			else
				wr_field_reg <= wr_field_reg + 2'h1;
		end
	end

	always @(posedge CLOCK) begin
		if (!RST_N) begin
			state_reg <= `VMI_ST_IDLE;
			cnt_reg <= 5'h00;
			x_reg <= 4'h0;
			xf_reg <= 4'h0;
			y_reg <= 4'h0;
			yf_reg <= 4'h0;
			sx_reg <= 4'h0;
			sxf_reg <= 4'h0;
			sy_reg <= 4'h0;
			syf_reg <= 4'h0;
			blank_reg <= 1'b0;
			phase_reg <= 1'b0;
			w_reg <= 14'h0000;
			sw_reg <= 14'h0000;
			acc_luma_reg <= 24'h000000;
			acc_chroma_reg <= 24'h000000;
			acc_key_reg <= 24'h000000;
			acc_shadow_reg <= 24'h000000;
			OUT_VALID <= 1'b0;
			OUT_LUMA <= 8'h00;
			OUT_CHROMA <= 8'h00;
			OUT_KEY <= 8'h00;
			OUT_SHADOW <= 8'h00;
		end else begin
			OUT_VALID <= 1'b0;
			case (state_reg)
				`VMI_ST_IDLE: begin
					if (ADDR_VALID) begin
						x_reg <= ADDR_X;
						xf_reg <= ADDR_XF;
						y_reg <= ADDR_Y;
						yf_reg <= ADDR_YF;
						sx_reg <= SHADOW_X;
						sxf_reg <= SHADOW_XF;
						sy_reg <= SHADOW_Y;
						syf_reg <= SHADOW_YF;
						blank_reg <= BLANK;
						cnt_reg <= 5'h00;
						acc_luma_reg <= 24'h000000;
						acc_chroma_reg <= 24'h000000;
						acc_key_reg <= 24'h000000;
						acc_shadow_reg <= 24'h000000;
						state_reg <= `VMI_ST_FETCH;
					end
				end
				`VMI_ST_FETCH: begin
					if (cnt_reg != `VMI_TAPS) begin
						w_reg <= {7'h00, weight(xf_reg, tap_x)} * {7'h00, weight(yf_reg, tap_y)};
						sw_reg <= {7'h00, weight(sxf_reg, tap_x)} * {7'h00, weight(syf_reg, tap_y)};
					end
					if (cnt_reg != 5'h00) begin
						acc_luma_reg <= mac(acc_luma_reg, rd_luma_reg, w_reg);
						acc_chroma_reg <= mac(acc_chroma_reg, rd_chroma_reg, w_reg);
						acc_key_reg <= mac(acc_key_reg, rd_key_reg, w_reg);
						acc_shadow_reg <= mac(acc_shadow_reg, rd_shadow_reg, sw_reg);
					end
					if (cnt_reg == `VMI_TAPS)
						state_reg <= `VMI_ST_DONE;
					else
						cnt_reg <= cnt_reg + 5'h01;
				end
				`VMI_ST_DONE: begin
					OUT_VALID <= 1'b1;
					OUT_LUMA <= blank_reg ? 8'h00 : acc_luma_reg[`VMI_OUT_LSB+7:`VMI_OUT_LSB];
					OUT_CHROMA <= blank_reg ? 8'h00 : acc_chroma_reg[`VMI_OUT_LSB+7:`VMI_OUT_LSB];
					if (key_upd)
						OUT_KEY <= blank_reg ? 8'h00 : acc_key_reg[`VMI_OUT_LSB+7:`VMI_OUT_LSB];
					if (shadow_upd)
						OUT_SHADOW <= blank_reg ? 8'h00 : acc_shadow_reg[`VMI_OUT_LSB+7:`VMI_OUT_LSB];
					else if (!half_mode)
						OUT_SHADOW <= 8'h00;
					phase_reg <= half_mode ? ~phase_reg : 1'b0;
					state_reg <= `VMI_ST_IDLE;
				end
				default: state_reg <= `VMI_ST_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// file: verification/vmi_filt_model.sv
/* Filter stage model: writes one column-ordered field, then ends it.
   Assumes the bench calls send_field between requests. */
`timescale 1ns/1ps
`default_nettype none
module vmi_filt_model (
	input  wire logic       clock,
	output logic            wr_valid,
	output logic [3:0]      wr_col,
	output logic [3:0]      wr_row,
	output logic [7:0]      wr_luma,
	output logic [7:0]      wr_chroma,
	output logic [7:0]      wr_key,
	output logic            field_end
);
	logic [7:0] base_reg = 8'h00;
	function automatic logic [23:0] pix(input logic [7:0] a);
		return {a ^ base_reg, a + base_reg, {a[3:0], a[7:4]} ^ base_reg};
	endfunction
	initial begin
		{wr_valid, field_end, wr_col, wr_row, wr_luma, wr_chroma, wr_key} = '0;
	end
	task automatic send_field(input logic [7:0] b);
		base_reg = b;
		for (int i = 0; i < 256; i++) begin
			@(negedge clock);
			wr_valid = 1'b1;
			{wr_row, wr_col} = i[7:0];
			{wr_luma, wr_chroma, wr_key} = pix(i[7:0]);
		end
		@(negedge clock);
		wr_valid = 1'b0;
		field_end = 1'b1;
		// Released lines invert so stale data never looks valid
		{wr_luma, wr_chroma, wr_key} = ~{wr_luma, wr_chroma, wr_key};
		@(negedge clock);
		field_end = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: verification/vmi_chk.sv
/* Checker of request timing, blanking and output hold.
   Bound to the interpolator top; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module vmi_chk (
	input wire logic       CLOCK,
	input wire logic       RST_N,
	input wire logic       ADDR_VALID,
	input wire logic       ADDR_READY,
	input wire logic       BLANK,
	input wire logic       UNIFIED_MODE,
	input wire logic       DUAL_KEY_UNIT,
	input wire logic       SHADOW_ENABLE,
	input wire logic       OUT_VALID,
	input wire logic [7:0] OUT_LUMA,
	input wire logic [7:0] OUT_CHROMA,
	input wire logic [7:0] OUT_SHADOW
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	wire acc = ADDR_VALID && ADDR_READY;
	property p_lat; acc |-> ##19 OUT_VALID; endproperty
	a_lat: assert property (p_lat) else $error("answer late or missing");
	property p_busy; acc |=> !ADDR_READY [*8]; endproperty
	a_busy: assert property (p_busy) else $error("ready during fetch");
	property p_one; OUT_VALID |=> !OUT_VALID; endproperty
	a_one: assert property (p_one) else $error("answer longer than one cycle");
	property p_cause; OUT_VALID |-> $past(acc, 19); endproperty
	a_cause: assert property (p_cause) else $error("answer without request");
	property p_rdy; OUT_VALID |-> ADDR_READY; endproperty
	a_rdy: assert property (p_rdy) else $error("not ready in answer cycle");
	property p_blank; acc && BLANK |-> ##19 OUT_LUMA == 8'h00 && OUT_CHROMA == 8'h00; endproperty
	a_blank: assert property (p_blank) else $error("blanked pixel not zero");
	property p_hold; RST_N && $past(RST_N) && !OUT_VALID |-> $stable(OUT_LUMA)
		&& $stable(OUT_SHADOW); endproperty
	a_hold: assert property (p_hold) else $error("output changed without answer");
	property p_noshd; acc && !UNIFIED_MODE && !DUAL_KEY_UNIT && !SHADOW_ENABLE
		|-> ##19 OUT_SHADOW == 8'h00; endproperty
	a_noshd: assert property (p_noshd) else $error("shadow in key-only mode");
endmodule
`default_nettype wire

// file: verification/testbench.sv
/* Self-checking bench: fields from the filter model, random requests.
   Assumes the interpolator, its defines and the model compile first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clock = 0, rst_n = 0, av = 0, blank = 0, uni = 0, dual = 0, shen = 0;
	logic [15:0] am = '0, sa = '0;
	logic        wv, fe, ar, ov;
	logic [3:0]  wc, wr;
	logic [7:0]  wl, wch, wk, ol, oc, ok, os, el, ec, ek, es;
	int          error_cnt = 0, n_checks = 0, ph, m;
	always #12.5 clock = ~clock;
	vmi_filt_model fm (.clock(clock), .wr_valid(wv), .wr_col(wc), .wr_row(wr), .wr_luma(wl),
		.wr_chroma(wch), .wr_key(wk), .field_end(fe));
	vmi_interpolator DUT (.CLOCK(clock), .RST_N(rst_n), .IN_VALID(wv), .IN_COL(wc),
		.IN_ROW(wr), .IN_LUMA(wl), .IN_CHROMA(wch), .IN_KEY(wk), .IN_FIELD_END(fe),
		.ADDR_VALID(av), .ADDR_READY(ar), .ADDR_X(am[15:12]), .ADDR_XF(am[11:8]),
		.ADDR_Y(am[7:4]), .ADDR_YF(am[3:0]), .SHADOW_X(sa[15:12]), .SHADOW_XF(sa[11:8]),
		.SHADOW_Y(sa[7:4]), .SHADOW_YF(sa[3:0]), .BLANK(blank), .UNIFIED_MODE(uni),
		.DUAL_KEY_UNIT(dual), .SHADOW_ENABLE(shen), .OUT_VALID(ov), .OUT_LUMA(ol),
		.OUT_CHROMA(oc), .OUT_KEY(ok), .OUT_SHADOW(os));
	function automatic int w(input int f, t);
		return t == 0 ? 16 - f : t == 1 ? 32 - f : t == 2 ? 16 + f : f;
	endfunction
	function automatic int cl(input int v);
		return v < 0 ? 0 : v > 15 ? 15 : v;
	endfunction
	function automatic logic [7:0] interp(input int ch, input logic [15:0] a);
		int          acc;
		logic [23:0] p;
		acc = 0;
		for (int j = 0; j < 4; j++)
			for (int i = 0; i < 4; i++) begin
				p = fm.pix({4'(cl(int'(a[7:4]) + j - 1)), 4'(cl(int'(a[15:12]) + i - 1))});
				acc += int'(p[8*ch +: 8]) * w(int'(a[11:8]), i) * w(int'(a[3:0]), j);
			end
		return acc[19:12];
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic req(input logic [15:0] a, s, input logic b);
		int         n;
		logic [7:0] kk, ss;
		n = 0;
		@(negedge clock);
		{am, sa, blank, av} = {a, s, b, 1'b1};
		chk("ready", 8'h01, {7'h00, ar});
		@(posedge clock);
		do begin
			@(negedge clock);
			n++;
			if (n == 1)
				{am, sa, blank, av} = {~a, ~s, ~b, 1'b0};
		end while (ov !== 1'b1 && n < 30);
		chk("latency", 8'h13, n[7:0]);
		if (n == 30)
			complete_run();
		kk = b ? 8'h00 : interp(0, a);
		ss = b ? 8'h00 : interp(0, s);
		el = b ? 8'h00 : interp(2, a);
		ec = b ? 8'h00 : interp(1, a);
		if (m == 0 || m == 3)
			{ek, es} = {kk, ss};
		else if (m == 1)
			{ek, es} = {kk, 8'h00};
		else begin
			if (ph == 0)
				ek = kk;
			else
				es = ss;
			ph ^= 1;
		end
		chk("luma", el, ol);
		chk("chroma", ec, oc);
		chk("key", ek, ok);
		chk("shadow", es, os);
	endtask
	initial begin
		void'($urandom(10662));
		repeat (20) @(negedge clock);
		rst_n = 1;
		for (m = 0; m < 4; m++) begin
			fm.send_field(8'($urandom));
			{uni, dual, shen} = m == 0 ? 3'h4 : m == 1 ? 3'h0 : m == 2 ? 3'h1 : 3'h2;
			ph = 0;
			for (int k = 0; k < 6; k++)
				req(k == 0 ? 16'h0000 : k == 1 ? 16'hffff : 16'($urandom), 16'($urandom),
					k > 1 && $urandom_range(3) == 0);
			$display("test mode %0d done", m);
		end
		rst_n = 0;
		repeat (2) @(negedge clock);
		chk("ready_rst", 8'h00, {7'h00, ar});
		chk("luma_rst", 8'h00, ol);
		chk("shadow_rst", 8'h00, os);
		rst_n = 1;
		@(negedge clock);
		chk("ready_rel", 8'h01, {7'h00, ar});
		chk("valid_rel", 8'h00, {7'h00, ov});
		complete_run();
	end
endmodule
bind vmi_interpolator vmi_chk u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR_VALID(ADDR_VALID),
	.ADDR_READY(ADDR_READY), .BLANK(BLANK), .UNIFIED_MODE(UNIFIED_MODE),
	.DUAL_KEY_UNIT(DUAL_KEY_UNIT), .SHADOW_ENABLE(SHADOW_ENABLE), .OUT_VALID(OUT_VALID),
	.OUT_LUMA(OUT_LUMA), .OUT_CHROMA(OUT_CHROMA), .OUT_SHADOW(OUT_SHADOW));
`default_nettype wire
